//--- hdl/mzb_pkg.sv
// Shared constants, field layout and decode helpers for the base mode register link.
// Assumes both link ends run on the same 20 MHz system clock.
package mzb_pkg;

	localparam int MR_W     = 19;
	localparam int BL_LSB   = 0;
	localparam int BT_BIT   = 3;
	localparam int CL_LO    = 2;
	localparam int CL_LSB   = 4;
	localparam int DLLR_BIT = 8;
	localparam int WR_LSB   = 9;
	localparam int PPD_BIT  = 12;
	localparam int CHOP_BIT = 12;

	localparam logic [18:0] MR_RESET     = 19'h00000;
	localparam logic [18:0] MR_RSVD_MASK = 19'h4E080;
	localparam logic [1:0]  BASE_SEL     = 2'h0;

	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [1:0] BL_CHOP4  = 2'h2;

	// Cycle counts at 50 ns per clock
	localparam int CK_NS      = 50;
	localparam int TWR_NS     = 15;
	localparam int TXP_NS     = 24;
	localparam int TXPDLL_NS  = 240;
	localparam int TWR_CYC    = (TWR_NS + CK_NS - 1) / CK_NS;
	localparam logic [4:0] TXP_CYC    = 5'((TXP_NS + CK_NS - 1) / CK_NS);
	localparam logic [4:0] TXPDLL_CYC = 5'((TXPDLL_NS + CK_NS - 1) / CK_NS);
	localparam logic [9:0] DLLK_CYC   = 10'h200;
	localparam logic [3:0] WL_CYC     = 4'h5;
	localparam logic [4:0] TMRD_CYC   = 5'h04;

	function automatic logic [3:0] cl_cycles(input logic [18:0] mr);
		logic [3:0] f;
		f = {1'b0, mr[CL_LSB+2:CL_LSB]};
		if (mr[CL_LO]) begin
			cl_cycles = (f > 4'h2) ? 4'hE : 4'hC + f;
		end else begin
			cl_cycles = (f == 4'h0) ? 4'h5 : 4'h4 + f;
		end
	endfunction

	function automatic logic [3:0] wr_cycles(input logic [2:0] code);
		case (code)
			3'h1:    wr_cycles = 4'h5;
			3'h2:    wr_cycles = 4'h6;
			3'h3:    wr_cycles = 4'h7;
			3'h4:    wr_cycles = 4'h8;
			3'h5:    wr_cycles = 4'hA;
			default: wr_cycles = 4'hC;
		endcase
	endfunction

	function automatic logic [2:0] wr_code(input int cyc);
		if (cyc <= 5) wr_code = 3'h1;
		else if (cyc <= 8) wr_code = 3'(cyc - 4);
		else if (cyc <= 10) wr_code = 3'h5;
		else wr_code = 3'h6;
	endfunction

	// Reserved length code 11 falls back to eight beats
	function automatic logic is_chop(input logic [18:0] mr, input logic a12);
		is_chop = (mr[BL_LSB+1:BL_LSB] == BL_CHOP4) || (mr[BL_LSB+1:BL_LSB] == BL_OTF && !a12);
	endfunction

endpackage

//--- hdl/mzb_link_if.sv
// Command and data link between the memory controller end and the DRAM end.
// Both ends are clocked by the same system clock; the data wire is resolved here.
`timescale 1ns/1ps
interface mzb_link_if;
	logic        cmd_mrs;
	logic        cmd_rd;
	logic        cmd_wr;
	logic [2:0]  ba;
	logic [15:0] addr;
	logic        cke;
	logic [7:0]  host_dq;
	logic        host_dq_oe;
	logic [7:0]  dev_dq;
	logic        dev_dq_oe;
	logic        dev_dqs_oe;
	logic [7:0]  dq;

	// Undriven wire reads as zero
	assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 8'h00);

	modport ctrl (
		output cmd_mrs, cmd_rd, cmd_wr, ba, addr, cke, host_dq, host_dq_oe,
		input  dq, dev_dq_oe, dev_dqs_oe
	);
	modport dram (
		input  cmd_mrs, cmd_rd, cmd_wr, ba, addr, cke, dq,
		output dev_dq, dev_dq_oe, dev_dqs_oe
	);
endinterface

//--- hdl/mzb_beat_order.sv
// Column order inside a burst block: maps beat number to low column bits.
// Pure combinational; the caller supplies a start column already masked for writes.
`timescale 1ns/1ps
module mzb_beat_order (
	input  wire logic [2:0] start,
	input  wire logic [2:0] beat,
	input  wire logic       interleave,
	output logic      [2:0] col
);
	assign col = interleave ? (start ^ beat)                                  // see R08
		: {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};              // see R07 R03
endmodule

//--- hdl/mzb_dram_end.sv
// DRAM end of the link: base mode register, DLL reset and lock, burst engine.
// Assumes the controller end keeps command spacing; reads and writes arriving mid-burst are ignored, mode loads are not.
//
// What the two link ends do
// R01 - Burst length from mode bits 1:0
// R02 - On-the-fly: A12 low chops, high full
// R03 - Burst wraps inside aligned column block
// R04 - One length for reads and writes
// R05 - Mode bit 3 picks sequential or interleaved
// R06 - Controller writes reserved mode bits as zero
// R07 - Sequential reads rotate within group of four
// R08 - Interleaved beat k reads start XOR k
// R09 - Chopped read tri-states last four slots
// R10 - Writes ignore low start column bits
// R11 - Chop and full bursts start alike
// R12 - DLL reset bit self-clears after start
// R13 - Controller waits 512 clocks before reads
// R14 - Write recovery from mode bits 11:9
// R15 - Controller rounds write recovery upward
// R16 - Bit 12 low stops DLL in power-down
// R17 - Bit 12 high keeps DLL running
// R18 - Read latency from mode latency bits
// R19 - Read latency five to fourteen cycles
// R20 - Controller loads mode only when idle
// R21 - Length codes: 00 eight, 10 chop, 11 reserved
`timescale 1ns/1ps
module mzb_dram_end (
	input  wire logic        CLK_SYS,
	input  wire logic        ARST_N,
	mzb_link_if.dram         LINK,
	output logic      [18:0] MODE_REG,
	output logic             DLL_RUNNING,
	output logic             DLL_LOCKED,
	output logic             WR_BUSY
);

	typedef enum logic [2:0] {
		DS_IDLE,
		DS_RLAT,
		DS_RDATA,
		DS_WLAT,
		DS_WDATA,
		DS_WREC
	} mzb_dev_st_t;

	// Mode and DLL state
	logic [18:0] mr;
	logic [18:0] next_mr;
	logic [9:0]  lock_cnt;
	logic [9:0]  next_lock_cnt;
	logic        locked;
	logic        next_locked;
	logic        dll_run;
	logic        next_dll_run;

	always_comb begin
		next_mr = mr;
		if (mr[mzb_pkg::DLLR_BIT]) begin
			next_mr[mzb_pkg::DLLR_BIT] = 1'b0;                          // see R12
		end
		if (LINK.cmd_mrs && LINK.ba[1:0] == mzb_pkg::BASE_SEL) begin
			next_mr = {LINK.ba, LINK.addr};
		end
		// The DLL idles only in power-down and only when the slow-exit mode is chosen
		next_dll_run = LINK.cke | mr[mzb_pkg::PPD_BIT];                 // see R16 R17
		next_lock_cnt = lock_cnt;
		next_locked = locked;
		if (mr[mzb_pkg::DLLR_BIT]) begin
			next_lock_cnt = mzb_pkg::DLLK_CYC;                          // see R12
			next_locked = 1'b0;
		end else if (lock_cnt != 10'h000 && dll_run && LINK.cke) begin
			next_lock_cnt = lock_cnt - 10'h001;
			if (lock_cnt == 10'h001) begin
				next_locked = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			mr <= mzb_pkg::MR_RESET;
			lock_cnt <= 10'h000;
			locked <= 1'b0;
			dll_run <= 1'b0;
		end else begin
			mr <= next_mr;
			lock_cnt <= next_lock_cnt;
			locked <= next_locked;
			dll_run <= next_dll_run;
		end
	end

	assign MODE_REG = mr;
	assign DLL_LOCKED = locked;
	assign DLL_RUNNING = dll_run;

	// Burst engine state
	mzb_dev_st_t st;
	mzb_dev_st_t next_st;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [2:0]  beat;
	logic [2:0]  next_beat;
	logic [2:0]  start;
	logic [2:0]  next_start;
	logic [2:0]  blk;
	logic [2:0]  next_blk;
	logic        chop;
	logic        next_chop;
	logic        ilv;
	logic        next_ilv;
	logic [7:0]  dq;
	logic [7:0]  next_dq;
	logic        oe;
	logic        next_oe;
	logic        wbusy;
	logic        next_wbusy;
	logic [2:0]  beat_col;
	logic        we;
	logic [5:0]  maddr;

	// Small column store standing in for the array
	logic [7:0]  mem [0:63];

	mzb_beat_order u_order (
		.start      (start),
		.beat       (beat),
		.interleave (ilv),
		.col        (beat_col)
	);

	assign maddr = {blk, beat_col};                                      // see R03

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_beat = beat;
		next_start = start;
		next_blk = blk;
		next_chop = chop;
		next_ilv = ilv;
		next_dq = dq;
		next_oe = 1'b0;
		we = 1'b0;
		unique case (st)
			DS_IDLE: begin
				if (LINK.cmd_rd || LINK.cmd_wr) begin
					// Same length decode serves both directions
					next_chop = mzb_pkg::is_chop(mr, LINK.addr[mzb_pkg::CHOP_BIT]); // see R01 R02 R04 R21
					next_ilv = mr[mzb_pkg::BT_BIT];                     // see R05
					next_blk = LINK.addr[5:3];
					next_beat = 3'h0;
					if (LINK.cmd_rd) begin
						next_start = LINK.addr[2:0];
						next_cnt = mzb_pkg::cl_cycles(mr);              // see R18 R19
						next_st = DS_RLAT;
					end else begin
						next_start = next_chop ? {LINK.addr[2], 2'h0} : 3'h0; // see R10
						next_cnt = mzb_pkg::WL_CYC;
						next_st = DS_WLAT;
					end
				end
			end
			DS_RLAT: begin
				if (cnt == 4'h1) begin
					next_dq = mem[maddr];
					next_oe = 1'b1;
					next_beat = beat + 3'h1;
					next_st = DS_RDATA;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			DS_RDATA: begin
				if (beat == 3'h0) begin
					next_st = DS_IDLE;
				end else begin
					// Chopped reads keep all eight slots so timing matches a full burst
					next_dq = mem[maddr];
					next_oe = ~(chop & beat[2]);                        // see R09 R11
					next_beat = beat + 3'h1;
				end
			end
			DS_WLAT: begin
				if (cnt == 4'h1) begin
					we = 1'b1;
					next_beat = beat + 3'h1;
					next_st = DS_WDATA;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			DS_WDATA: begin
				if (beat == 3'h0) begin
					next_cnt = mzb_pkg::wr_cycles(mr[mzb_pkg::WR_LSB+2:mzb_pkg::WR_LSB]); // see R14
					next_st = DS_WREC;
				end else begin
					we = ~(chop & beat[2]);                             // see R10 R11
					next_beat = beat + 3'h1;
				end
			end
			DS_WREC: begin
				if (cnt == 4'h1) begin
					next_st = DS_IDLE;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
		endcase
		next_wbusy = (next_st == DS_WREC);
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			st <= DS_IDLE;
			cnt <= 4'h0;
			beat <= 3'h0;
			start <= 3'h0;
			blk <= 3'h0;
			chop <= 1'b0;
			ilv <= 1'b0;
			dq <= 8'h00;
			oe <= 1'b0;
			wbusy <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			beat <= next_beat;
			start <= next_start;
			blk <= next_blk;
			chop <= next_chop;
			ilv <= next_ilv;
			dq <= next_dq;
			oe <= next_oe;
			wbusy <= next_wbusy;
		end
	end

	// Array has no reset; it holds data, not control
	always_ff @(posedge CLK_SYS) begin
		if (we) begin
			mem[maddr] <= LINK.dq;
		end
	end

	assign LINK.dev_dq = dq;
	assign LINK.dev_dq_oe = oe;
	assign LINK.dev_dqs_oe = oe;
	assign WR_BUSY = wbusy;

endmodule

//--- hdl/mzb_ctrl_end.sv
// Controller end of the link: loads the base mode register, issues bursts, paces exits.
// Assumes all banks are precharged whenever it is idle; no activate or refresh is issued.
`timescale 1ns/1ps
module mzb_ctrl_end (
	input  wire logic        CLK_SYS,
	input  wire logic        ARST_N,
	mzb_link_if.ctrl         LINK,
	input  wire logic        REQ_MRS,
	input  wire logic [18:0] MRS_VALUE,
	input  wire logic        REQ_RD,
	input  wire logic        REQ_WR,
	input  wire logic [9:0]  REQ_COL,
	input  wire logic        REQ_CHOP,
	input  wire logic [63:0] WDATA,
	input  wire logic        PD_REQ,
	output logic             READY,
	output logic      [63:0] RDATA,
	output logic             RVALID
);

	typedef enum logic [2:0] {
		HS_IDLE,
		HS_GAP,
		HS_RD,
		HS_WR,
		HS_PD
	} mzb_host_st_t;

	mzb_host_st_t st;
	mzb_host_st_t next_st;
	logic [4:0]  cnt;
	logic [4:0]  next_cnt;
	logic [3:0]  beat;
	logic [3:0]  next_beat;
	logic [18:0] shadow;
	logic [18:0] next_shadow;
	logic [9:0]  dll_wait;
	logic [9:0]  next_dll_wait;
	logic        chop;
	logic        next_chop;
	logic [63:0] wbuf;
	logic [63:0] next_wbuf;
	logic        cmd_mrs;
	logic        next_cmd_mrs;
	logic        cmd_rd;
	logic        next_cmd_rd;
	logic        cmd_wr;
	logic        next_cmd_wr;
	logic [2:0]  ba;
	logic [2:0]  next_ba;
	logic [15:0] addr;
	logic [15:0] next_addr;
	logic        cke;
	logic        next_cke;
	logic [7:0]  hdq;
	logic [7:0]  next_hdq;
	logic        hoe;
	logic        next_hoe;
	logic [63:0] rdata;
	logic [63:0] next_rdata;
	logic        rvalid;
	logic        next_rvalid;
	logic        ready;
	logic        next_ready;

	always_comb begin
		logic [18:0] v;
		v = (MRS_VALUE & ~mzb_pkg::MR_RSVD_MASK);                          // see R06
		v[mzb_pkg::WR_LSB+2:mzb_pkg::WR_LSB] = mzb_pkg::wr_code(mzb_pkg::TWR_CYC); // see R15
		next_st = st;
		next_cnt = cnt;
		next_beat = beat;
		next_shadow = shadow;
		next_dll_wait = dll_wait;
		next_chop = chop;
		next_wbuf = wbuf;
		next_cmd_mrs = 1'b0;
		next_cmd_rd = 1'b0;
		next_cmd_wr = 1'b0;
		next_ba = ba;
		next_addr = addr;
		next_cke = cke;
		next_hdq = hdq;
		next_hoe = hoe;
		next_rdata = rdata;
		next_rvalid = 1'b0;
		if (dll_wait != 10'h000 && cke) begin
			next_dll_wait = dll_wait - 10'h001;                              // see R13
		end
		unique case (st)
			HS_IDLE: begin
				// Only idle with nothing in flight may a mode load go out
				if (ready && REQ_MRS) begin                                  // see R20
					next_cmd_mrs = 1'b1;
					next_ba = v[18:16];
					next_addr = v[15:0];
					if (v[17:16] == mzb_pkg::BASE_SEL) begin
						next_shadow = v;
					end
					if (v[mzb_pkg::DLLR_BIT]) begin
						next_dll_wait = mzb_pkg::DLLK_CYC;                   // see R13
					end
					next_cnt = mzb_pkg::TMRD_CYC;
					next_st = HS_GAP;
				end else if (ready && (REQ_RD || REQ_WR)) begin
					next_ba = 3'h0;
					next_addr = {3'h0, ~REQ_CHOP, 2'h0, REQ_COL};            // see R02
					next_chop = mzb_pkg::is_chop(shadow, ~REQ_CHOP);
					next_beat = 4'h0;
					if (REQ_RD) begin
						next_cmd_rd = 1'b1;
						next_rdata = 64'h0;
						next_cnt = {1'b0, mzb_pkg::cl_cycles(shadow)} + 5'h02;
						next_st = HS_RD;
					end else begin
						next_cmd_wr = 1'b1;
						next_wbuf = WDATA;
						next_cnt = {1'b0, mzb_pkg::WL_CYC};
						next_st = HS_WR;
					end
				end else if (ready && PD_REQ) begin
					next_cke = 1'b0;
					next_st = HS_PD;
				end
			end
			HS_GAP: begin
				if (cnt == 5'h01) begin
					next_st = HS_IDLE;
				end else begin
					next_cnt = cnt - 5'h01;
				end
			end
			HS_RD: begin
				if (cnt != 5'h01) begin
					next_cnt = cnt - 5'h01;
				end else begin
					next_rdata[{beat[2:0], 3'h0} +: 8] = LINK.dev_dq_oe ? LINK.dq : 8'h00;
					next_beat = beat + 4'h1;
					if (beat == 4'h7) begin
						next_rvalid = 1'b1;
						next_st = HS_IDLE;
					end
				end
			end
			HS_WR: begin
				if (cnt != 5'h01) begin
					next_cnt = cnt - 5'h01;
				end else if (beat == 4'h8) begin
					next_hoe = 1'b0;
					next_cnt = {1'b0, mzb_pkg::wr_cycles(shadow[mzb_pkg::WR_LSB+2:mzb_pkg::WR_LSB])};
					next_st = HS_GAP;
				end else begin
					next_hdq = wbuf[{beat[2:0], 3'h0} +: 8];
					next_hoe = ~(chop & beat[2]);
					next_beat = beat + 4'h1;
				end
			end
			HS_PD: begin
				if (!PD_REQ) begin
					next_cke = 1'b1;
					// Slow exit when the DLL was stopped, fast exit when it kept running
					next_cnt = shadow[mzb_pkg::PPD_BIT] ? mzb_pkg::TXP_CYC : mzb_pkg::TXPDLL_CYC; // see R16 R17
					next_st = HS_GAP;
				end
			end
		endcase
		next_ready = (next_st == HS_IDLE) && (next_dll_wait == 10'h000);
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			st <= HS_IDLE;
			cnt <= 5'h00;
			beat <= 4'h0;
			shadow <= mzb_pkg::MR_RESET;
			dll_wait <= 10'h000;
			chop <= 1'b0;
			wbuf <= 64'h0;
			cmd_mrs <= 1'b0;
			cmd_rd <= 1'b0;
			cmd_wr <= 1'b0;
			ba <= 3'h0;
			addr <= 16'h0000;
			cke <= 1'b1;
			hdq <= 8'h00;
			hoe <= 1'b0;
			rdata <= 64'h0;
			rvalid <= 1'b0;
			ready <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			beat <= next_beat;
			shadow <= next_shadow;
			dll_wait <= next_dll_wait;
			chop <= next_chop;
			wbuf <= next_wbuf;
			cmd_mrs <= next_cmd_mrs;
			cmd_rd <= next_cmd_rd;
			cmd_wr <= next_cmd_wr;
			ba <= next_ba;
			addr <= next_addr;
			cke <= next_cke;
			hdq <= next_hdq;
			hoe <= next_hoe;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			ready <= next_ready;
		end
	end

	assign LINK.cmd_mrs = cmd_mrs;
	assign LINK.cmd_rd = cmd_rd;
	assign LINK.cmd_wr = cmd_wr;
	assign LINK.ba = ba;
	assign LINK.addr = addr;
	assign LINK.cke = cke;
	assign LINK.host_dq = hdq;
	assign LINK.host_dq_oe = hoe;
	assign READY = ready;
	assign RDATA = rdata;
	assign RVALID = rvalid;

endmodule

//--- tb/mzb_link_assertions.sv
// Protocol checker for the link between the controller end and the DRAM end.
// Assumes one clock for both ends and signals taken straight from the link interface.
`timescale 1ns/1ps
module mzb_link_assertions (
	input  wire logic        CLK_SYS,
	input  wire logic        ARST_N,
	input  wire logic        cmd_mrs,
	input  wire logic        cmd_rd,
	input  wire logic        cmd_wr,
	input  wire logic [2:0]  ba,
	input  wire logic [15:0] addr,
	input  wire logic        cke,
	input  wire logic        host_dq_oe,
	input  wire logic        dev_dq_oe,
	input  wire logic        dev_dqs_oe
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);

	logic [18:0] mode;
	logic        chop;
	logic [4:0]  rd_cnt;
	logic [9:0]  dll_cnt;
	logic [2:0]  f;
	logic [4:0]  cl;
	logic        mrs0;
	logic        any_cmd;

	assign mrs0 = cmd_mrs && ba[1:0] == 2'h0;
	assign any_cmd = cmd_mrs || cmd_rd || cmd_wr;
	assign f = mode[6:4];
	assign cl = mode[2] ? ((f > 3'h2) ? 5'hE : 5'hC + f) : ((f == 3'h0) ? 5'h5 : 5'h4 + f);

	// Shadow of the loaded mode; the lock counter starts saturated since no DLL reset is pending after reset
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			mode <= 19'h00000;
			chop <= 1'b0;
			rd_cnt <= 5'h00;
			dll_cnt <= 10'h200;
		end else begin
			if (mrs0)
				mode <= {ba, addr};
			if (cmd_rd || cmd_wr)
				chop <= (mode[1:0] == 2'h2) || (mode[1:0] == 2'h1 && !addr[12]);
			rd_cnt <= cmd_rd ? 5'h00 : ((rd_cnt == 5'h1F) ? rd_cnt : rd_cnt + 5'h01);
			if (mrs0 && addr[8])
				dll_cnt <= 10'h000;
			else if (cke && dll_cnt != 10'h200)
				dll_cnt <= dll_cnt + 10'h001;
		end
	end

	AST_STROBE_WITH_DATA: assert property (dev_dqs_oe == dev_dq_oe)
		else $error("strobe enable differs from data enable");
	AST_RESERVED_ZERO: assert property (mrs0 |-> ({ba, addr} & mzb_pkg::MR_RSVD_MASK) == 19'h00000)
		else $error("reserved mode bits loaded nonzero");
	AST_WR_CODE: assert property (mrs0 |-> addr[11:9] == 3'h1)
		else $error("write recovery code not rounded up to five cycles");
	AST_MRS_SPACING: assert property (cmd_mrs |=> !cmd_mrs [*3])
		else $error("mode loads closer than four cycles");
	AST_READ_AFTER_LOCK: assert property (cmd_rd |-> dll_cnt == 10'h200)
		else $error("read issued before lock wait ended");
	AST_READ_LATENCY: assert property ($rose(dev_dq_oe) |-> rd_cnt == cl)
		else $error("read data not at programmed latency");
	AST_READ_CHOP: assert property ($rose(dev_dq_oe) && chop |-> dev_dq_oe [*4] ##1 !dev_dq_oe [*4])
		else $error("chopped read drives wrong slots");
	AST_READ_FULL: assert property ($rose(dev_dq_oe) && !chop |-> dev_dq_oe [*8] ##1 !dev_dq_oe)
		else $error("full read not eight beats");
	AST_WRITE_START: assert property (cmd_wr |-> ##5 $rose(host_dq_oe))
		else $error("write data not five cycles after command");
	AST_WRITE_LEN: assert property ($rose(host_dq_oe) |-> host_dq_oe [*4] ##1 (host_dq_oe != chop))
		else $error("write burst length wrong");
	AST_SLOW_EXIT: assert property ($rose(cke) && !mode[12] |-> !any_cmd [*5])
		else $error("command too soon after slow power-down exit");
	AST_NO_CLASH: assert property (!(dev_dq_oe && host_dq_oe))
		else $error("both ends drive data");
endmodule

//--- tb/sdram_mode_zero_burst_control_bench.sv
// Self-checking bench: controller end and DRAM end joined by the link interface.
// Assumes a 20 MHz clock; expected bytes come from a local copy of the array.
`timescale 1ns/1ps
module sdram_mode_zero_burst_control_bench;
	logic        CLK_SYS;
	logic        ARST_N;
	logic        REQ_MRS;
	logic [18:0] MRS_VALUE;
	logic        REQ_RD;
	logic        REQ_WR;
	logic [9:0]  REQ_COL;
	logic        REQ_CHOP;
	logic [63:0] WDATA;
	logic        PD_REQ;
	logic        READY;
	logic [63:0] RDATA;
	logic        RVALID;
	logic [18:0] MODE_REG;
	logic        DLL_RUNNING;
	logic        DLL_LOCKED;
	logic        WR_BUSY;
	int          fail_count;
	int          samples_checked;
	logic [7:0]  mem [64];
	logic [63:0] wd;
	logic [1:0]  blc;
	logic        eff;

	mzb_link_if u_mzb_link_if ();
	mzb_ctrl_end u_mzb_ctrl_end (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .LINK(u_mzb_link_if.ctrl),
		.REQ_MRS(REQ_MRS), .MRS_VALUE(MRS_VALUE), .REQ_RD(REQ_RD), .REQ_WR(REQ_WR), .REQ_COL(REQ_COL),
		.REQ_CHOP(REQ_CHOP), .WDATA(WDATA), .PD_REQ(PD_REQ), .READY(READY), .RDATA(RDATA), .RVALID(RVALID));
	mzb_dram_end u_mzb_dram_end (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .LINK(u_mzb_link_if.dram),
		.MODE_REG(MODE_REG), .DLL_RUNNING(DLL_RUNNING), .DLL_LOCKED(DLL_LOCKED), .WR_BUSY(WR_BUSY));
	mzb_link_assertions u_mzb_link_assertions (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
		.cmd_mrs(u_mzb_link_if.cmd_mrs), .cmd_rd(u_mzb_link_if.cmd_rd), .cmd_wr(u_mzb_link_if.cmd_wr),
		.ba(u_mzb_link_if.ba), .addr(u_mzb_link_if.addr), .cke(u_mzb_link_if.cke),
		.host_dq_oe(u_mzb_link_if.host_dq_oe), .dev_dq_oe(u_mzb_link_if.dev_dq_oe),
		.dev_dqs_oe(u_mzb_link_if.dev_dqs_oe));

	initial CLK_SYS = 1'b0;
	always #25 CLK_SYS = ~CLK_SYS;

	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Bounded so a stuck handshake ends as a mismatch, not a hang
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(negedge CLK_SYS);
			n++;
		end while (READY !== 1'b1 && n < 3000);
		chk_val(64'(READY), 64'h1, "ready");
	endtask

	task automatic issue(input int kind);
		wait_ready;
		REQ_MRS = (kind == 0);
		REQ_RD = (kind == 1);
		REQ_WR = (kind == 2);
		PD_REQ = (kind == 3);
		@(negedge CLK_SYS);
		REQ_MRS = 1'b0;
		REQ_RD = 1'b0;
		REQ_WR = 1'b0;
	endtask

	// Reserved bits are set on purpose; the stored value must come back with them clear
	task automatic do_mrs(input logic [18:0] v);
		MRS_VALUE = v | mzb_pkg::MR_RSVD_MASK;
		issue(0);
		wait_ready;
		chk_val(64'(MODE_REG), 64'((v & ~mzb_pkg::MR_RSVD_MASK & ~19'h00F00) | 19'h00200), "mode");
	endtask

	task automatic do_wr(input logic [9:0] col, input logic chop);
		int n;
		int base;
		REQ_COL = col;
		WDATA = wd;
		issue(2);
		n = 0;
		repeat (30) begin
			@(negedge CLK_SYS);
			if (WR_BUSY === 1'b1)
				n++;
		end
		chk_val(64'(n), 64'h5, "recovery cycles");
		base = col[5:3] * 8 + (chop ? col[2] * 4 : 0);
		for (int k = 0; k < (chop ? 4 : 8); k++)
			mem[base + k] = wd[8 * k +: 8];
		wd = wd + 64'h0808080808080808;
	endtask

	task automatic do_rd(input logic [9:0] col, input logic chop, input logic il);
		int n;
		logic [63:0] e;
		logic [2:0] c;
		e = 64'h0;
		for (int k = 0; k < (chop ? 4 : 8); k++) begin
			c = il ? col[2:0] ^ 3'(k) : {col[2] ^ k[2], col[1:0] + k[1:0]};
			e[8 * k +: 8] = mem[{col[5:3], c}];
		end
		REQ_COL = col;
		issue(1);
		n = 0;
		while (RVALID !== 1'b1 && n < 100) begin
			@(negedge CLK_SYS);
			n++;
		end
		chk_val(64'(RVALID), 64'h1, "read valid");
		chk_val(RDATA, e, "read data");
	endtask

	task automatic do_pd(input logic keep);
		issue(3);
		repeat (4) @(negedge CLK_SYS);
		chk_val(64'(DLL_RUNNING), 64'(keep), "dll in sleep");
		PD_REQ = 1'b0;
		wait_ready;
		chk_val(64'(DLL_RUNNING), 64'h1, "dll awake");
	endtask

	initial begin
		ARST_N = 1'b0;
		REQ_MRS = 1'b0;
		MRS_VALUE = 19'h00000;
		REQ_RD = 1'b0;
		REQ_WR = 1'b0;
		REQ_COL = 10'h000;
		REQ_CHOP = 1'b0;
		WDATA = 64'h0;
		PD_REQ = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		wd = 64'h0706050403020100;
		repeat (5) @(negedge CLK_SYS);
		chk_val(64'({MODE_REG, DLL_LOCKED, WR_BUSY, RVALID}), 64'h0, "reset state");
		ARST_N = 1'b1;
		do_mrs(19'h00100);
		// The controller frees the bus two cycles before the DRAM end reports lock
		chk_val(64'(DLL_LOCKED), 64'h0, "dll relocking");
		repeat (2) @(negedge CLK_SYS);
		chk_val(64'(DLL_LOCKED), 64'h1, "dll locked");
		$display("test dll reset done");
		// Start columns with low bits set: full writes must still fill the block in order
		for (int b = 0; b < 8; b++)
			do_wr(10'(8 * b + 3), 1'b0);
		$display("test block fill done");
		for (int bt = 0; bt < 2; bt++) begin
			// Mode 4: reserved length code must ignore a chop request; longest latency too
			for (int m = 0; m < 5; m++) begin
				blc = (m == 0) ? 2'h0 : ((m == 1) ? 2'h2 : ((m == 4) ? 2'h3 : 2'h1));
				eff = (m == 1) || (m == 2);
				REQ_CHOP = (m == 2) || (m == 4);
				do_mrs({6'h00, 1'(bt), 3'h6, 2'h0, 3'(m), 1'(bt), 1'(m == 4), blc});
				do_wr(10'(8 * m + 4 * bt + 1), eff);
				for (int s = 0; s < 8; s++)
					do_rd(10'(8 * m + s), eff, 1'(bt));
				do_pd(1'(bt));
				$display("test mode %0d order %0d done", m, bt);
			end
		end
		conclude;
	end

	initial begin
		repeat (20000) @(posedge CLK_SYS);
		fail_count++;
		$display("mismatch at %0t: run did not finish", $time);
		conclude;
	end
endmodule
